//--- opd_discriminator.sv
`timescale 1ns/100ps
`default_nettype none
`include "opd_consts.svh"
module opd_discriminator
    import opd_pkg::*;
#(
    parameter int unsigned NCH = `OPD_NCH,
    parameter int unsigned TR_MIN_CYC = int'(
        (`OPD_CLK_HZ * `OPD_MILLI
         + `OPD_TR_MILLIHZ + `OPD_TR_TOL_MILLIHZ - 64'd1)
        / (`OPD_TR_MILLIHZ + `OPD_TR_TOL_MILLIHZ)),
    parameter int unsigned TR_MAX_CYC = int'(
        (`OPD_CLK_HZ * `OPD_MILLI)
        / (`OPD_TR_MILLIHZ - `OPD_TR_TOL_MILLIHZ)),
    parameter int unsigned EM_MIN_CYC = int'(
        (`OPD_CLK_HZ * `OPD_MILLI
         + `OPD_EM_MILLIHZ + `OPD_EM_TOL_MILLIHZ - 64'd1)
        / (`OPD_EM_MILLIHZ + `OPD_EM_TOL_MILLIHZ)),
    parameter int unsigned EM_MAX_CYC = int'(
        (`OPD_CLK_HZ * `OPD_MILLI)
        / (`OPD_EM_MILLIHZ - `OPD_EM_TOL_MILLIHZ)),
    parameter int unsigned VALID_CYC = int'(
        (`OPD_CLK_HZ * `OPD_VALID_MS + `OPD_MILLI - 64'd1)
        / `OPD_MILLI),
    parameter int unsigned HOLD_SHORT_CYC = int'(
        (`OPD_CLK_HZ * `OPD_HOLD_SHORT_MS) / `OPD_MILLI),
    parameter int unsigned HOLD_LONG_CYC = int'(
        (`OPD_CLK_HZ * `OPD_HOLD_LONG_MS) / `OPD_MILLI),
    parameter int unsigned HALF_CYC = int'(
        (`OPD_CLK_HZ * `OPD_MILLI)
        / (`OPD_OUT_MILLIHZ * `OPD_HALVES))
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire opd_ch_in_t [NCH-1:0]  ch_in,
    output var  opd_ch_out_t [NCH-1:0] ch_out
);

    localparam opd_per_t  TR_LO      = opd_per_t'(TR_MIN_CYC);
    localparam opd_per_t  TR_HI      = opd_per_t'(TR_MAX_CYC);
    localparam opd_per_t  EM_LO      = opd_per_t'(EM_MIN_CYC);
    localparam opd_per_t  EM_HI      = opd_per_t'(EM_MAX_CYC);
    localparam opd_run_t  RUN_TOP    = opd_run_t'(VALID_CYC);
    localparam opd_hold_t HOLD_SHORT = opd_hold_t'(HOLD_SHORT_CYC);
    localparam opd_hold_t HOLD_LONG  = opd_hold_t'(HOLD_LONG_CYC);
    localparam opd_div_t  DIV_LAST   = opd_div_t'(HALF_CYC - 1);
    localparam opd_per_t  PER_SAT    = '1;

    typedef struct packed {
        opd_div_t                  div;
        logic                      sq;
        opd_ch_state_t [NCH-1:0]   ch;
    } opd_state_t;

    opd_state_t st;
    opd_state_t next_st;

    function automatic logic in_band(
        input opd_per_t p,
        input opd_per_t lo,
        input opd_per_t hi
    );
        return (p >= lo) && (p <= hi);
    endfunction

    function automatic opd_streak_t bump(input opd_streak_t s);
        return (s == '1) ? s : opd_streak_t'(s + 1'b1);
    endfunction

    // a range position beyond the last one counts as the last one
    function automatic opd_streak_t need(
        input opd_range_t  pos,
        input opd_streak_t base
    );
        opd_range_t p;
        p = (pos > `OPD_RANGE_MAX) ? `OPD_RANGE_MAX : pos;
        return opd_streak_t'({1'b0, p} + base);
    endfunction

    function automatic opd_run_t run_step(
        input logic     det,
        input opd_run_t run
    );
        if (!det) begin
            return '0;
        end
        return (run == RUN_TOP) ? run : opd_run_t'(run + 1'b1);
    endfunction

    // hold reloads while the signal is present, so a dropout always
    // gets the full hold period however long the call has lasted
    function automatic opd_call_t call_step(
        input logic      det,
        input logic      done,
        input logic      call,
        input opd_hold_t hold,
        input opd_hold_t load
    );
        opd_call_t r;
        r.call = call;
        r.hold = hold;
        if (det) begin
            r.hold = load;
            r.call = call | done;
        end else if (call) begin
            if (hold == '0) begin
                r.call = 1'b0;
            end else begin
                r.hold = opd_hold_t'(hold - 1'b1);
            end
        end
        return r;
    endfunction

    always_comb begin
        logic      merged;
        logic      edge_seen;
        logic      inb_tr;
        logic      inb_em;
        logic      em_eff;
        logic      tr_eff;
        opd_per_t  p;
        opd_hold_t load;
        opd_call_t c;
        merged    = 1'b0;
        edge_seen = 1'b0;
        inb_tr    = 1'b0;
        inb_em    = 1'b0;
        em_eff    = 1'b0;
        tr_eff    = 1'b0;
        p         = '0;
        load      = '0;
        c         = '0;
        next_st   = st;
        if (st.div == DIV_LAST) begin
            next_st.div = '0;
            next_st.sq  = ~st.sq;
        end else begin
            next_st.div = opd_div_t'(st.div + 1'b1);
        end
        for (int i = 0; i < NCH; i++) begin
            merged = ch_in[i].det_primary | (|ch_in[i].det_aux); // R18 R11
            edge_seen = merged & ~st.ch[i].prev_in;
            next_st.ch[i].prev_in = merged;
            p = st.ch[i].period;
            inb_tr = in_band(p, TR_LO, TR_HI); // R2 R19
            inb_em = in_band(p, EM_LO, EM_HI); // R3 R19
            if (edge_seen) begin
                // the edge cycle itself counts, so p is the full spacing
                next_st.ch[i].period = opd_per_t'(1'b1);
                // a stray short gap from a second emitter breaks the run
                next_st.ch[i].streak_tr =
                    inb_tr ? bump(st.ch[i].streak_tr) : '0;
                next_st.ch[i].streak_em =
                    inb_em ? bump(st.ch[i].streak_em) : '0; // R5
            end else begin
                // zero means no edge since reset: the first edge never counts
                if ((p != PER_SAT) && (p != '0)) begin
                    next_st.ch[i].period = opd_per_t'(p + 1'b1);
                end
                if (p > EM_HI) begin
                    next_st.ch[i].streak_em = '0;
                end
                if (p > TR_HI) begin
                    next_st.ch[i].streak_tr = '0;
                end
            end
            next_st.ch[i].det_tr = next_st.ch[i].streak_tr >=
                need(ch_in[i].range_tr, `OPD_TR_STREAK_BASE); // R12 R14
            next_st.ch[i].det_em = next_st.ch[i].streak_em >=
                need(ch_in[i].range_em, `OPD_EM_STREAK_BASE); // R12 R5
            next_st.ch[i].run_tr =
                run_step(next_st.ch[i].det_tr, st.ch[i].run_tr); // R4
            next_st.ch[i].run_em =
                run_step(next_st.ch[i].det_em, st.ch[i].run_em); // R4
            load = ch_in[i].hold_long ? HOLD_LONG : HOLD_SHORT; // R7
            c = call_step(next_st.ch[i].det_tr,
                          st.ch[i].run_tr == RUN_TOP,
                          st.ch[i].call_tr, st.ch[i].hold_tr, load); // R6
            next_st.ch[i].call_tr = c.call;
            next_st.ch[i].hold_tr = c.hold;
            c = call_step(next_st.ch[i].det_em,
                          st.ch[i].run_em == RUN_TOP,
                          st.ch[i].call_em, st.ch[i].hold_em, load); // R6
            next_st.ch[i].call_em = c.call;
            next_st.ch[i].hold_em = c.hold;
            // test calls bypass hold, so release drops them at once
            next_st.ch[i].tst_em = ch_in[i].test_em; // R13 R20
            next_st.ch[i].tst_tr =
                ch_in[i].test_tr & ~ch_in[i].test_em; // R13 R20
            em_eff = next_st.ch[i].call_em | next_st.ch[i].tst_em;
            tr_eff = next_st.ch[i].call_tr | next_st.ch[i].tst_tr;
            next_st.ch[i].oe = em_eff | (tr_eff & next_st.sq); // R9 R10 R17
            next_st.ch[i].lamp_tr = tr_eff ? 1'b1 :
                (next_st.ch[i].det_tr & next_st.sq); // R16 R15
            next_st.ch[i].lamp_em = em_eff ? 1'b1 :
                (next_st.ch[i].det_em & next_st.sq); // R16 R15
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ch_out[i].pull_oe   = st.ch[i].oe; // R8 R1
            ch_out[i].pull_o    = `OPD_PULL_LEVEL; // R8
            ch_out[i].lamp_tr   = st.ch[i].lamp_tr;
            ch_out[i].lamp_em   = st.ch[i].lamp_em;
            ch_out[i].detect_tr = st.ch[i].det_tr; // R14
            ch_out[i].detect_em = st.ch[i].det_em; // R14
            ch_out[i].call_tr   = st.ch[i].call_tr | st.ch[i].tst_tr;
            ch_out[i].call_em   = st.ch[i].call_em | st.ch[i].tst_em;
        end
    end

    a_ch_count: assert property (@(posedge clk) disable iff (!arst_n) // R1
        (NCH >= `OPD_NCH_MIN) && (NCH <= `OPD_NCH_MAX))
        else $error("channel count out of range");

    a_sq_half: assert property (@(posedge clk) disable iff (!arst_n) // R9
        $changed(st.sq) |-> $past(st.div) == DIV_LAST)
        else $error("square wave half period wrong");

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        sequence s_em_active;
            st.ch[g].call_em || st.ch[g].tst_em;
        endsequence
        sequence s_tr_only;
            (st.ch[g].call_tr || st.ch[g].tst_tr) && !st.ch[g].call_em
                && !st.ch[g].tst_em;
        endsequence
        sequence s_em_ready;
            st.ch[g].det_em && st.ch[g].run_em == RUN_TOP;
        endsequence

        a_em_steady: assert property (@(posedge clk) // R10
            disable iff (!arst_n) s_em_active |-> st.ch[g].oe)
            else $error("emergency call output not steady");

        a_tr_square: assert property (@(posedge clk) // R9
            disable iff (!arst_n) s_tr_only |-> st.ch[g].oe == st.sq)
            else $error("transit output does not follow square wave");

        a_em_valid: assert property (@(posedge clk) // R4
            disable iff (!arst_n)
            s_em_ready ##1 st.ch[g].det_em |-> st.ch[g].call_em)
            else $error("valid emergency signal not accepted");

        a_tr_early: assert property (@(posedge clk) // R4
            disable iff (!arst_n)
            $rose(st.ch[g].call_tr) |-> $past(st.ch[g].run_tr) == RUN_TOP)
            else $error("transit call accepted too early");

        a_hold_drop: assert property (@(posedge clk) // R6
            disable iff (!arst_n)
            $fell(st.ch[g].call_em) |-> $past(st.ch[g].hold_em) == '0
                && !$past(st.ch[g].det_em))
            else $error("emergency call dropped before hold ran out");

        a_em_streak: assert property (@(posedge clk) // R5
            disable iff (!arst_n)
            $rose(st.ch[g].det_em) |-> st.ch[g].streak_em
                >= `OPD_EM_STREAK_BASE)
            else $error("emergency detect on a single period");

        a_test_release: assert property (@(posedge clk) // R20
            disable iff (!arst_n)
            $fell(st.ch[g].tst_em) && !st.ch[g].call_em
                && !st.ch[g].call_tr && !st.ch[g].tst_tr
                |-> !st.ch[g].oe)
            else $error("test call held after release");

        a_merge_in: assert property (@(posedge clk) // R18
            disable iff (!arst_n)
            $past(arst_n) |-> st.ch[g].prev_in == $past(ch_in[g].det_primary
                | (|ch_in[g].det_aux)))
            else $error("detector inputs not merged");

        a_lamp_flash: assert property (@(posedge clk) // R16
            disable iff (!arst_n)
            st.ch[g].det_tr && !st.ch[g].call_tr && !st.ch[g].tst_tr
                |-> st.ch[g].lamp_tr == st.sq)
            else $error("detect lamp not flashing");

        a_hold_load: assert property (@(posedge clk) // R7
            disable iff (!arst_n)
            st.ch[g].det_em |-> st.ch[g].hold_em
                == ($past(ch_in[g].hold_long) ? HOLD_LONG : HOLD_SHORT))
            else $error("hold period not loaded from setting");

        a_test_up: assert property (@(posedge clk) // R13
            disable iff (!arst_n)
            ch_in[g].test_em |=> st.ch[g].tst_em && st.ch[g].oe)
            else $error("up test switch gave no emergency call");

        a_test_down: assert property (@(posedge clk) // R13
            disable iff (!arst_n)
            ch_in[g].test_tr && !ch_in[g].test_em
                |=> st.ch[g].tst_tr && !st.ch[g].tst_em)
            else $error("down test switch gave no transit call");
    end

endmodule
`default_nettype wire

//--- opd_consts.svh
// Notes on behaviour
// (R1) two to four channels, each own output
// (R2) transit class at 9.639 Hz +/- 0.119
// (R3) emergency class at 14.035 Hz +/- 0.255
// (R4) call only after over half second steady
// (R5) many transit emitters never read as emergency
// (R6) hold call through dropout, 4.5 to 11 s
// (R7) hold selectable 5 s or 10 s
// (R8) asserted output pulls controller input to ground
// (R9) transit call output 6.25 Hz square, 50 percent
// (R10) emergency call output steadily asserted
// (R11) two auxiliary detector inputs per channel
// (R12) three range positions per class per channel
// (R13) test switch forces transit down, emergency up
// (R14) detection lamp shows unvalidated received signal
// (R15) call lamp shows accepted steady valid signal
// (R16) shared lamp flashes detect, steady for call
// (R17) emergency call overrides transit call
// (R18) primary and auxiliary inputs ORed together
// (R19) classify by edge-to-edge period on system clock
// (R20) releasing test switch ends call without hold
`ifndef OPD_CONSTS_SVH
`define OPD_CONSTS_SVH

`define OPD_CLK_HZ          64'd125000000
`define OPD_MILLI           64'd1000
`define OPD_TR_MILLIHZ      64'd9639
`define OPD_TR_TOL_MILLIHZ  64'd119
`define OPD_EM_MILLIHZ      64'd14035
`define OPD_EM_TOL_MILLIHZ  64'd255
`define OPD_VALID_MS        64'd500
`define OPD_HOLD_SHORT_MS   64'd5000
`define OPD_HOLD_LONG_MS    64'd10000
`define OPD_OUT_MILLIHZ     64'd6250
`define OPD_HALVES          64'd2

`define OPD_NCH             2
`define OPD_NCH_MIN         2
`define OPD_NCH_MAX         4
`define OPD_AUX_N           2
`define OPD_PER_W           24
`define OPD_RUN_W           27
`define OPD_HOLD_W          32
`define OPD_DIV_W           24
`define OPD_STREAK_W        3
`define OPD_RANGE_W         2

`define OPD_RANGE_MAX       2'd2
`define OPD_TR_STREAK_BASE  3'd1
`define OPD_EM_STREAK_BASE  3'd2
`define OPD_PULL_LEVEL      1'b0

`endif

//--- opd_pkg.sv
`default_nettype none
`include "opd_consts.svh"
package opd_pkg;
    typedef logic [`OPD_PER_W-1:0]    opd_per_t;
    typedef logic [`OPD_RUN_W-1:0]    opd_run_t;
    typedef logic [`OPD_HOLD_W-1:0]   opd_hold_t;
    typedef logic [`OPD_DIV_W-1:0]    opd_div_t;
    typedef logic [`OPD_STREAK_W-1:0] opd_streak_t;
    typedef logic [`OPD_RANGE_W-1:0]  opd_range_t;

    typedef struct packed {
        logic                  det_primary;
        logic [`OPD_AUX_N-1:0] det_aux;
        logic                  test_tr;
        logic                  test_em;
        opd_range_t            range_tr;
        opd_range_t            range_em;
        logic                  hold_long;
    } opd_ch_in_t;

    typedef struct packed {
        logic pull_oe;
        logic pull_o;
        logic lamp_tr;
        logic lamp_em;
        logic detect_tr;
        logic detect_em;
        logic call_tr;
        logic call_em;
    } opd_ch_out_t;

    typedef struct packed {
        logic      call;
        opd_hold_t hold;
    } opd_call_t;

    typedef struct packed {
        logic        prev_in;
        opd_per_t    period;
        opd_streak_t streak_tr;
        opd_streak_t streak_em;
        logic        det_tr;
        logic        det_em;
        opd_run_t    run_tr;
        opd_run_t    run_em;
        logic        call_tr;
        logic        call_em;
        opd_hold_t   hold_tr;
        opd_hold_t   hold_em;
        logic        tst_tr;
        logic        tst_em;
        logic        oe;
        logic        lamp_tr;
        logic        lamp_em;
    } opd_ch_state_t;
endpackage
`default_nettype wire

//--- opd_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module opd_far_side (
    input  wire logic        clk,
    input  wire logic        en,
    input  wire logic [15:0] period,
    input  wire logic        pull_oe,
    input  wire logic        pull_o,
    output logic             pulse,
    output logic             ctrl_level
);
    logic [15:0] cnt;

    // emitter flashes are short fixed bursts; only the spacing carries class
    always @(negedge clk) begin
        if (!en || cnt >= period - 16'h1) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 16'h1;
        end
    end
    assign pulse = en && (cnt < 16'h4);
    // controller input has a pull-up, so a released output reads high
    assign ctrl_level = pull_oe ? pull_o : 1'b1;
endmodule
`default_nettype wire

//--- opd_discriminator_test.sv
`timescale 1ns/100ps
`default_nettype none
module opd_discriminator_test;
    import opd_pkg::*;
    localparam int NCH   = 2;
    localparam int VALID = 300;
    localparam int HSH   = 100;
    localparam int HLG   = 200;
    localparam int HALF  = 8;
    localparam int TR_P  = 103;
    localparam int EM_P  = 71;
    localparam int B_OE  = 7;
    localparam int B_LTR = 5;
    localparam int B_LEM = 4;
    localparam int B_DTR = 3;
    localparam int B_DEM = 2;
    localparam int B_CTR = 1;
    localparam int B_CEM = 0;

    logic                  clk;
    logic                  arst_n;
    opd_ch_in_t [NCH-1:0]  cfg;
    opd_ch_in_t [NCH-1:0]  ch_in;
    opd_ch_out_t [NCH-1:0] ch_out;
    logic                  em_en;
    logic [15:0]           em_period;
    logic [1:0]            route;
    logic                  pulse;
    logic                  ctrl_level;
    int                    n_errors;
    int                    n_compared;
    int                    d;
    int                    k;

    opd_discriminator #(.NCH(NCH), .TR_MIN_CYC(102), .TR_MAX_CYC(105),
        .EM_MIN_CYC(70), .EM_MAX_CYC(72), .VALID_CYC(VALID),
        .HOLD_SHORT_CYC(HSH), .HOLD_LONG_CYC(HLG), .HALF_CYC(HALF)
    ) opd_discriminator_i (
        .clk    (clk),
        .arst_n (arst_n),
        .ch_in  (ch_in),
        .ch_out (ch_out)
    );

    opd_far_side opd_far_side_i (
        .clk        (clk),
        .en         (em_en),
        .period     (em_period),
        .pull_oe    (ch_out[0].pull_oe),
        .pull_o     (ch_out[0].pull_o),
        .pulse      (pulse),
        .ctrl_level (ctrl_level)
    );

    always_comb begin
        ch_in = cfg;
        ch_in[0].det_primary = cfg[0].det_primary | (pulse && route == 2'h0);
        ch_in[0].det_aux[0] = cfg[0].det_aux[0] | (pulse && route == 2'h1);
        ch_in[0].det_aux[1] = cfg[0].det_aux[1] | (pulse && route == 2'h2);
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // bounded wait; returns the number of falling edges it took
    task automatic wait_flag(input int ch, input int b, input logic v,
                             output int n);
        n = 0;
        while (ch_out[ch][b] !== v && n < 2000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 2000) check("wait_flag", 32'h0, 32'h1);
    endtask

    task automatic emit(input int p, input logic [1:0] r);
        em_period = p[15:0];
        route = r;
        em_en = 1'b1;
    endtask

    // starts from a low phase so a half-seen high never gets measured
    task automatic measure_sq(input int ch);
        int n;
        wait_flag(ch, B_OE, 1'b0, n);
        wait_flag(ch, B_OE, 1'b1, n);
        wait_flag(ch, B_OE, 1'b0, n);
        check("sq_high", n, HALF);
        wait_flag(ch, B_OE, 1'b1, n);
        check("sq_low", n, HALF);
    endtask

    task automatic summarize();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        summarize();
    end

    initial begin
        n_errors = 0;
        n_compared = 0;
        arst_n = 1'b0;
        cfg = '0;
        em_en = 1'b0;
        em_period = 16'h0;
        route = 2'h0;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        check("out_idle", ch_out, 32'h0);
        check("ctrl_idle", ctrl_level, 32'h1);
        cfg[1].test_em = 1'b1;
        @(negedge clk);
        check("tst_em_call", ch_out[1][B_CEM], 32'h1);
        check("tst_em_oe", ch_out[1][B_OE], 32'h1);
        check("ch0_quiet", ch_out[0], 32'h0);
        cfg[1].test_tr = 1'b1;
        @(negedge clk);
        check("tst_both_oe", ch_out[1][B_OE], 32'h1);
        cfg[1].test_em = 1'b0;
        @(negedge clk);
        check("tst_tr_call", ch_out[1][B_CTR], 32'h1);
        measure_sq(1);
        cfg[1].test_tr = 1'b0;
        @(negedge clk);
        check("tst_release", ch_out[1], 32'h0);
        cfg[1].test_em = 1'b1;
        @(negedge clk);
        check("tst_em_lamp", ch_out[1][B_LEM], 32'h1);
        cfg[1].test_em = 1'b0;
        @(negedge clk);
        check("tst_em_release", ch_out[1], 32'h0);
        // each range position on a different detector input
        for (int r = 0; r < 3; r++) begin
            cfg[0].range_tr = r[1:0];
            cfg[0].range_em = r[1:0];
            emit(TR_P, r[1:0]);
            wait_flag(0, B_DTR, 1'b1, d);
            check("tr_periods", d / TR_P, r + 1);
            check("tr_not_em", ch_out[0][B_DEM], 32'h0);
            k = 0;
            repeat (2 * HALF + 1) begin
                @(negedge clk);
                k += ch_out[0][B_LTR];
            end
            check("lamp_flash", k > 0 && k < 2 * HALF + 1, 32'h1);
            em_en = 1'b0;
            wait_flag(0, B_DTR, 1'b0, d);
            check("short_no_call", ch_out[0][B_CTR], 32'h0);
            emit(EM_P, r[1:0]);
            wait_flag(0, B_DEM, 1'b1, d);
            check("em_periods", d / EM_P, r + 2);
            check("em_not_tr", ch_out[0][B_DTR], 32'h0);
            em_en = 1'b0;
            wait_flag(0, B_DEM, 1'b0, d);
        end
        cfg[0].range_tr = 2'h0;
        cfg[0].range_em = 2'h0;
        emit(90, 2'h0);
        repeat (400) @(negedge clk);
        check("off_band", ch_out[0][B_DTR:B_DEM], 32'h0);
        em_en = 1'b0;
        repeat (200) @(negedge clk);
        emit(TR_P, 2'h1);
        wait_flag(0, B_DTR, 1'b1, d);
        wait_flag(0, B_CTR, 1'b1, d);
        check("valid_delay", d, VALID);
        measure_sq(0);
        check("ctrl_low", ctrl_level, 32'h0);
        check("lamp_steady", ch_out[0][B_LTR], 32'h1);
        em_en = 1'b0;
        wait_flag(0, B_DTR, 1'b0, d);
        wait_flag(0, B_CTR, 1'b0, d);
        check("hold_short", d, HSH);
        cfg[0].hold_long = 1'b1;
        emit(EM_P, 2'h2);
        wait_flag(0, B_CEM, 1'b1, d);
        cfg[0].test_tr = 1'b1;
        k = 0;
        repeat (2 * HALF + 2) begin
            @(negedge clk);
            k += ch_out[0][B_OE];
        end
        check("em_steady", k, 2 * HALF + 2);
        check("tr_raw_call", ch_out[0][B_CTR], 32'h1);
        check("lamp_em_steady", ch_out[0][B_LEM], 32'h1);
        cfg[0].test_tr = 1'b0;
        em_en = 1'b0;
        wait_flag(0, B_DEM, 1'b0, d);
        wait_flag(0, B_CEM, 1'b0, d);
        check("hold_long", d, HLG);
        summarize();
    end
endmodule
`default_nettype wire
